// File: rtl/msf_defs.svh
`ifndef MSF_DEFS_SVH
`define MSF_DEFS_SVH
`define MSF_ID_STOP        8'h00
`define MSF_ID_SEEN        8'h01
`define MSF_ID_LINK        8'h02
`define MSF_ID_LIMIT       8'h03
`define MSF_ID_RESET       8'h7F
`define MSF_ERR_MASK       16'h03FF
`define MSF_LINK_MASK      16'h003E
`define MSF_LIMIT_MASK     16'h03FF
`define MSF_SWITCH_LEVEL   16'sh0640
`define MSF_RC_EXT_PIN     8'h04
`define MSF_RC_POWER       8'h0C
`define MSF_RC_SOFTWARE    8'h14
`define MSF_RC_WATCHDOG    8'h24
`define MSF_FLASH_MS       2000
`define MSF_CLK_MHZ        100
`define MSF_FLASH_CYCLES   (`MSF_FLASH_MS * 1000 * `MSF_CLK_MHZ)
`define MSF_BLINK_CYCLES   25000000
`endif

// File: rtl/msf_pkg.sv
package msf_pkg;
  typedef enum logic [2:0] {
    MSF_IDLE = 3'b001,
    MSF_LOW  = 3'b010,
    MSF_HIGH = 3'b100
  } msf_tx_state_t;
  typedef logic [15:0] msf_word_t;
endpackage

// File: rtl/msf_read_if.sv
`timescale 1ns/1ps
`default_nettype none
interface msf_read_if;
  logic       req;
  logic [7:0] id;
  logic       busy;
  logic       taken;
  modport fsm  (input req, input id, output busy, output taken);
  modport bank (output req, output id, input busy, input taken);
endinterface
`default_nettype wire

// File: rtl/msf_byte_tx.sv
`timescale 1ns/1ps
`default_nettype none
`include "msf_defs.svh"
module msf_byte_tx
  import msf_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  msf_read_if.fsm         rd,
  input  wire logic [15:0] word,
  input  wire logic       byte_ready,
  output logic [7:0]      byte_data,
  output logic            byte_valid
);
  msf_tx_state_t state;
  logic [7:0]    high_byte;

  assign rd.busy  = (state != MSF_IDLE);
  assign rd.taken = rd.req && (state == MSF_IDLE);

  // low byte first, then high byte
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state      <= MSF_IDLE;
      byte_data  <= 8'h00;
      byte_valid <= 1'b0;
      high_byte  <= 8'h00;
    end else begin
      unique case (state)
        MSF_IDLE: begin
          if (rd.req) begin
            byte_data  <= word[7:0];
            high_byte  <= word[15:8];
            byte_valid <= 1'b1;
            state      <= MSF_LOW;
          end
        end
        MSF_LOW: begin
          if (byte_ready) begin
            byte_data <= high_byte;
            state     <= MSF_HIGH;
          end
        end
        MSF_HIGH: begin
          if (byte_ready) begin
            byte_valid <= 1'b0;
            state      <= MSF_IDLE;
          end
        end
        default: state <= MSF_IDLE;
      endcase
    end
  end

  low_first_a: assert property (@(posedge clk) disable iff (!rst_n)
    rd.taken |=> byte_valid && byte_data == $past(word[7:0]))
    else $error("low byte not sent first");
  high_second_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state == MSF_LOW && byte_ready) |=> byte_valid && byte_data == $past(high_byte))
    else $error("high byte not sent second");
endmodule
`default_nettype wire

// File: rtl/msf_status_bank.sv
`timescale 1ns/1ps
`default_nettype none
`include "msf_defs.svh"
module msf_status_bank
  import msf_pkg::*;
#(
  parameter int FLASH_CYCLES = `MSF_FLASH_CYCLES,
  parameter int BLINK_CYCLES = `MSF_BLINK_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [9:0]  stop_error_in,
  input  wire logic [4:0]  link_error_evt,
  input  wire logic [4:0]  limit_cond_in,
  input  wire logic [3:0]  switch_enable,
  input  wire logic [15:0] pulse_channel_one,
  input  wire logic [15:0] pulse_channel_two,
  input  wire logic [15:0] analog_channel_one,
  input  wire logic [15:0] analog_channel_two,
  input  wire logic        usb_kill,
  input  wire logic [3:0]  reset_source,
  input  wire logic        read_req,
  input  wire logic [7:0]  read_id,
  output logic             read_busy,
  output logic             read_bad_id,
  input  wire logic        byte_ready,
  output logic [7:0]       byte_data,
  output logic             byte_valid,
  output logic             motor_enable,
  output logic             yellow_led
);
  msf_read_if rd ();
  msf_word_t  current_stop_errors;
  msf_word_t  sticky_errors_seen;
  msf_word_t  sticky_link_errors;
  msf_word_t  output_limit_flags;
  msf_word_t  reset_cause_code;
  msf_word_t  read_word;
  logic       captured;
  logic [31:0] flash_cnt;
  logic [31:0] blink_cnt;
  logic [3:0]  blink_num;
  logic        rd_seen;
  logic        rd_link;

  function automatic logic switch_on(input logic [15:0] v);
    return $signed(v) >= `MSF_SWITCH_LEVEL;
  endfunction

  assign rd.req      = read_req;
  assign rd.id       = read_id;
  assign read_busy   = rd.busy;
  assign read_bad_id = read_req && !rd.busy && !(read_id inside {`MSF_ID_STOP,
                       `MSF_ID_SEEN, `MSF_ID_LINK, `MSF_ID_LIMIT, `MSF_ID_RESET});
  assign rd_seen = rd.taken && read_id == `MSF_ID_SEEN;
  assign rd_link = rd.taken && read_id == `MSF_ID_LINK;

  always_comb begin
    unique case (rd.id)
      `MSF_ID_STOP:  read_word = current_stop_errors;
      `MSF_ID_SEEN:  read_word = sticky_errors_seen;
      `MSF_ID_LINK:  read_word = sticky_link_errors;
      `MSF_ID_LIMIT: read_word = output_limit_flags;
      `MSF_ID_RESET: read_word = reset_cause_code;
      default:       read_word = 16'h0000;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) current_stop_errors <= 16'h0000;
    else current_stop_errors <= {6'h00, stop_error_in};
  end

  assign motor_enable = (current_stop_errors == 16'h0000);

  // a new error in the read cycle survives the clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) sticky_errors_seen <= 16'h0000;
    else sticky_errors_seen <= (rd_seen ? 16'h0000 : sticky_errors_seen)
                               | {6'h00, stop_error_in};
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) sticky_link_errors <= 16'h0000;
    else sticky_link_errors <= (rd_link ? 16'h0000 : sticky_link_errors)
                               | {10'h000, link_error_evt, 1'b0};
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) output_limit_flags <= 16'h0000;
    else output_limit_flags <= {6'h00, usb_kill,
      switch_enable[3] && switch_on(analog_channel_two),
      switch_enable[2] && switch_on(analog_channel_one),
      switch_enable[1] && switch_on(pulse_channel_two),
      switch_enable[0] && switch_on(pulse_channel_one),
      limit_cond_in[4:1], limit_cond_in[0] | (|stop_error_in)};
  end

  // cause sampled at first clock after release, never again
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      captured         <= 1'b0;
      reset_cause_code <= 16'h0000;
    end else if (!captured) begin
      captured <= 1'b1;
      priority case (1'b1)
        reset_source[0]: reset_cause_code <= {8'h00, `MSF_RC_EXT_PIN};
        reset_source[1]: reset_cause_code <= {8'h00, `MSF_RC_POWER};
        reset_source[2]: reset_cause_code <= {8'h00, `MSF_RC_SOFTWARE};
        reset_source[3]: reset_cause_code <= {8'h00, `MSF_RC_WATCHDOG};
        default:         reset_cause_code <= 16'h0000;
      endcase
    end
  end

  // even slots light; cause bits 5:3 plus one pulses per sixteen slots
  // bits 5:3 differ for all four causes, bits 7:5 would not
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flash_cnt  <= 32'h0;
      blink_cnt  <= 32'h0;
      blink_num  <= 4'h0;
      yellow_led <= 1'b0;
    end else if (captured && flash_cnt < FLASH_CYCLES) begin
      flash_cnt <= flash_cnt + 32'h1;
      if (blink_cnt >= BLINK_CYCLES - 1) begin
        blink_cnt <= 32'h0;
        blink_num <= blink_num + 4'h1;
        yellow_led <= !blink_num[0]
                      && ({1'b0, blink_num[3:1]} < {1'b0, reset_cause_code[5:3]} + 4'h1);
      end else blink_cnt <= blink_cnt + 32'h1;
    end else yellow_led <= 1'b0;
  end

  msf_byte_tx u_tx (
    .clk        (clk),
    .rst_n      (rst_n),
    .rd         (rd.fsm),
    .word       (read_word),
    .byte_ready (byte_ready),
    .byte_data  (byte_data),
    .byte_valid (byte_valid)
  );

  motor_stop_a: assert property (@(posedge clk) disable iff (!rst_n)
    (|stop_error_in) |=> !motor_enable)
    else $error("motor enabled with error");
  seen_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    (rd_seen && stop_error_in == 10'h0) |=> sticky_errors_seen == 16'h0000)
    else $error("seen word not cleared");
  seen_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    !rd_seen |=> (sticky_errors_seen & $past(sticky_errors_seen))
                 == $past(sticky_errors_seen))
    else $error("seen bit lost");
  link_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    (rd_link && link_error_evt == 5'h0) |=> sticky_link_errors == 16'h0000)
    else $error("link word not cleared");
  link_reserved_a: assert property (@(posedge clk) disable iff (!rst_n)
    (sticky_link_errors & ~`MSF_LINK_MASK) == 16'h0000)
    else $error("link reserved bit set");
  limit_usb_a: assert property (@(posedge clk) disable iff (!rst_n)
    usb_kill |=> output_limit_flags[9])
    else $error("usb kill not flagged");
  limit_rsvd_a: assert property (@(posedge clk) disable iff (!rst_n)
    (output_limit_flags & ~`MSF_LIMIT_MASK) == 16'h0000)
    else $error("limit reserved bit set");
  cause_held_a: assert property (@(posedge clk) disable iff (!rst_n)
    captured |=> $stable(reset_cause_code))
    else $error("reset cause changed");
  stop_mirror_a: assert property (@(posedge clk) disable iff (!rst_n)
    1'b1 |=> current_stop_errors == {6'h00, $past(stop_error_in)})
    else $error("stop word mismatch");
endmodule
`default_nettype wire

// File: testbench/msf_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module msf_host_model (
  input  wire logic       clk,
  output logic            read_req,
  output logic [7:0]      read_id,
  input  wire logic       read_busy,
  output logic            byte_ready,
  input  wire logic [7:0] byte_data,
  input  wire logic       byte_valid
);
  initial begin
    read_req = 1'b0;
    read_id = 8'h00;
    byte_ready = 1'b0;
  end
  // data is taken at the edge where valid and ready are both high
  task automatic take_byte(output logic [7:0] b);
    while (byte_valid !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    b = byte_data;
    @(posedge clk);
    #1;
  endtask
  task automatic read_word(input logic [7:0] id, input int stall, output logic [15:0] w);
    while (read_busy !== 1'b0) begin
      @(posedge clk);
      #1;
    end
    read_req = 1'b1;
    read_id = id;
    @(posedge clk);
    #1;
    read_req = 1'b0;
    read_id = ~id;
    repeat (stall) begin
      @(posedge clk);
      #1;
    end
    byte_ready = 1'b1;
    take_byte(w[7:0]);
    take_byte(w[15:8]);
    byte_ready = 1'b0;
    @(posedge clk);
    #1;
  endtask
endmodule
`default_nettype wire

// File: testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import msf_pkg::*;
  localparam int FLASH = 2000;
  localparam logic [15:0] CAUSE [4] = '{16'h0004, 16'h000C, 16'h0014, 16'h0024};
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [9:0]  stop_error_in = 10'h000;
  logic [4:0]  link_error_evt = 5'h00;
  logic [4:0]  limit_cond_in = 5'h00;
  logic [3:0]  switch_enable = 4'h0;
  logic [3:0]  reset_source = 4'h1;
  logic [15:0] pulse_channel_one = 16'h0000;
  logic [15:0] pulse_channel_two = 16'h0000;
  logic [15:0] analog_channel_one = 16'h0000;
  logic [15:0] analog_channel_two = 16'h0000;
  logic        usb_kill = 1'b0;
  logic        read_req, read_busy, read_bad_id, byte_ready, byte_valid;
  logic        motor_enable, yellow_led;
  logic        bad_seen = 1'b0;
  logic [7:0]  read_id, byte_data;
  msf_word_t   w;
  int          n_mismatch = 0;
  int          n_compared = 0;
  always #5 clk = ~clk;
  always @(posedge clk) if (read_bad_id === 1'b1) bad_seen <= 1'b1;
  msf_status_bank #(.FLASH_CYCLES(FLASH), .BLINK_CYCLES(50)) u_msf_status_bank (
    .clk, .rst_n, .stop_error_in, .link_error_evt, .limit_cond_in, .switch_enable,
    .pulse_channel_one, .pulse_channel_two, .analog_channel_one, .analog_channel_two,
    .usb_kill, .reset_source, .read_req, .read_id, .read_busy, .read_bad_id,
    .byte_ready, .byte_data, .byte_valid, .motor_enable, .yellow_led);
  msf_host_model u_msf_host_model (.clk, .read_req, .read_id, .read_busy,
    .byte_ready, .byte_data, .byte_valid);
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rd(input logic [7:0] id, input int stall);
    u_msf_host_model.read_word(id, stall, w);
  endtask
  task automatic do_reset(input logic [3:0] src);
    reset_source = src;
    rst_n = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    rst_n = 1'b1;
    @(posedge clk);
    #1;
  endtask
  task automatic sc_stop();
    stop_error_in = 10'h201;
    repeat (2) @(posedge clk);
    #1;
    check({15'h0000, motor_enable}, 16'h0000);
    rd(8'h00, 0); check(w, 16'h0201);
    stop_error_in = 10'h000;
    @(posedge clk);
    #1;
    rd(8'h00, 3); check(w, 16'h0000);
    check({15'h0000, motor_enable}, 16'h0001);
    rd(8'h01, 0); check(w, 16'h0201);
    rd(8'h01, 2); check(w, 16'h0000);
  endtask
  task automatic sc_link();
    link_error_evt = 5'h11;
    @(posedge clk);
    #1;
    link_error_evt = 5'h02;
    @(posedge clk);
    #1;
    link_error_evt = 5'h00;
    rd(8'h02, 2); check(w, 16'h0026);
    rd(8'h02, 0); check(w, 16'h0000);
  endtask
  task automatic sc_limit();
    check({15'h0000, bad_seen}, 16'h0000);
    limit_cond_in = 5'h1E;
    switch_enable = 4'hB;
    pulse_channel_one = 16'h0640;
    pulse_channel_two = 16'hFFFF;
    analog_channel_one = 16'h0640;
    analog_channel_two = 16'h0C80;
    usb_kill = 1'b1;
    @(posedge clk);
    #1;
    rd(8'h03, 1); check(w, 16'h033E);
    pulse_channel_one = 16'h063F;
    usb_kill = 1'b0;
    @(posedge clk);
    #1;
    rd(8'h03, 0); check(w, 16'h011E);
    rd(8'h05, 0); check(w, 16'h0000);
    check({15'h0000, bad_seen}, 16'h0001);
  endtask
  task automatic sc_cause();
    for (int i = 0; i < 4; i++) begin
      do_reset(4'h1 << i);
      rd(8'h7F, 0); check(w, CAUSE[i]);
      reset_source = 4'h1 << ((i + 1) % 4);
      rd(8'h7F, 1); check(w, CAUSE[i]);
    end
  endtask
  task automatic sc_led();
    int   rises [2];
    logic prev;
    for (int k = 0; k < 2; k++) begin
      rises[k] = 0;
      prev = 1'b0;
      do_reset(4'h1 << (3 * k));
      repeat (FLASH) begin
        @(posedge clk);
        #1;
        if (yellow_led === 1'b1 && prev !== 1'b1) rises[k]++;
        prev = yellow_led;
      end
      check({15'h0000, rises[k] != 0}, 16'h0001);
      repeat (20) @(posedge clk);
      #1;
      check({15'h0000, yellow_led}, 16'h0000);
    end
    check({15'h0000, rises[0] != rises[1]}, 16'h0001);
  endtask
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    #1;
    rst_n = 1'b1;
    check({15'h0000, motor_enable}, 16'h0001);
    sc_stop();
    sc_link();
    sc_limit();
    sc_cause();
    sc_led();
    close_out();
  end
  initial begin
    #400000;
    n_mismatch++;
    close_out();
  end
endmodule
`default_nettype wire
